/* File: core/pcpc_map.svh */
`ifndef PCPC_MAP_SVH
`define PCPC_MAP_SVH

`define PCPC_ADDR_DIV_HI    8'h01
`define PCPC_ADDR_DIV_LO    8'h02
`define PCPC_ADDR_BAND_PUMP 8'h03
`define PCPC_ADDR_PHASE     8'h04
`define PCPC_ADDR_CTRL      8'h05
`define PCPC_ADDR_STATUS    8'h06

`define PCPC_BAND_LSB       6
`define PCPC_PUMP_LSB       3
`define PCPC_PHASE_LSB      3
`define PCPC_CTRL_SYNC_INV  0
`define PCPC_CTRL_COAST_INV 1
`define PCPC_CTRL_EXT_SEL   2
`define PCPC_STAT_LOCKED    0
`define PCPC_STAT_COAST     1

`define PCPC_RST_DIV        12'h53F
`define PCPC_RST_BAND       2'h1
`define PCPC_RST_PUMP       3'h5
`define PCPC_RST_PHASE      5'h00
`define PCPC_RST_CTRL       3'h0

`define PCPC_SYS_MHZ        100
`define PCPC_BAND0_MIN_MHZ  12
`define PCPC_BAND0_MAX_MHZ  35
`define PCPC_BAND1_MAX_MHZ  70
`define PCPC_BAND2_MAX_MHZ  110
`define PCPC_BAND3_MAX_MHZ  140
`define PCPC_PHASE_STEPS    32
`define PCPC_STEP_SHIFT     8
`define PCPC_LOCK_LINES     4'h8

`endif

/* File: core/pcpc_pkg.sv */
package pcpc_pkg;
  typedef logic [11:0] pcpc_div_t;
  typedef logic [31:0] pcpc_freq_t;
  typedef logic [7:0]  pcpc_byte_t;
  typedef enum logic [1:0] {
    PCPC_BAND_LOW  = 2'h0,
    PCPC_BAND_MID  = 2'h1,
    PCPC_BAND_HIGH = 2'h2,
    PCPC_BAND_TOP  = 2'h3
  } pcpc_band_e;
endpackage

/* File: core/pcpc_sync_cond.sv */
`timescale 1ns/1ps
`default_nettype none
module pcpc_sync_cond (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  input  wire logic i_invert,
  output logic      o_level,
  output logic      o_rise
);
  logic meta_r;
  logic safe_r;
  logic lvl_r;
  logic rise_r;
  logic lvl_nxt;
  logic rise_nxt;

  always_comb begin
    lvl_nxt  = safe_r ^ i_invert;
    rise_nxt = lvl_nxt & ~lvl_r;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b0;
      safe_r <= 1'b0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      meta_r <= i_async;
      safe_r <= meta_r;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign o_level = lvl_r;
  assign o_rise  = rise_r;
endmodule
`default_nettype wire

/* File: core/pcpc_pll_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pcpc_map.svh"
module pcpc_pll_ctrl (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire pcpc_pkg::pcpc_byte_t i_reg_addr,
  input  wire pcpc_pkg::pcpc_byte_t i_reg_wdata,
  output pcpc_pkg::pcpc_byte_t   o_reg_rdata,
  input  wire logic              i_hsync,
  input  wire logic              i_coast,
  input  wire logic              i_ext_clk,
  output logic                   o_sample_clk_en,
  output logic                   o_aligned_sync_output,
  output logic                   o_band_select_high,
  output logic                   o_band_select_low,
  output logic [2:0]             o_pump_code,
  output pcpc_pkg::pcpc_freq_t   o_freq_word,
  output logic                   o_locked
);
  import pcpc_pkg::*;

  // Band edge as accumulator step; saturates where the rate reaches the system clock
  function automatic pcpc_freq_t mhz_word(input int unsigned mhz);
    logic [63:0] w;
    w = (64'(mhz) << 32) / 64'(`PCPC_SYS_MHZ);
    mhz_word = (w > 64'h0000_0000_FFFF_FFFF) ? 32'hFFFF_FFFF : w[31:0];
  endfunction

  function automatic pcpc_freq_t band_min(input pcpc_band_e b);
    case (b)
      PCPC_BAND_LOW:  band_min = mhz_word(`PCPC_BAND0_MIN_MHZ);
      PCPC_BAND_MID:  band_min = mhz_word(`PCPC_BAND0_MAX_MHZ);
      PCPC_BAND_HIGH: band_min = mhz_word(`PCPC_BAND1_MAX_MHZ);
      default:        band_min = mhz_word(`PCPC_BAND2_MAX_MHZ);
    endcase
  endfunction

  function automatic pcpc_freq_t band_max(input pcpc_band_e b);
    case (b)
      PCPC_BAND_LOW:  band_max = mhz_word(`PCPC_BAND0_MAX_MHZ);
      PCPC_BAND_MID:  band_max = mhz_word(`PCPC_BAND1_MAX_MHZ);
      PCPC_BAND_HIGH: band_max = mhz_word(`PCPC_BAND2_MAX_MHZ);
      default:        band_max = mhz_word(`PCPC_BAND3_MAX_MHZ);
    endcase
  endfunction

  // Register group
  pcpc_div_t  div_r;
  pcpc_div_t  div_nxt;
  pcpc_band_e band_r;
  pcpc_band_e band_nxt;
  logic [2:0] pump_r;
  logic [2:0] pump_nxt;
  logic [4:0] phase_r;
  logic [4:0] phase_nxt;
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  pcpc_byte_t rdata_r;
  pcpc_byte_t rdata_nxt;
  logic       locked_r;
  logic       locked_nxt;

  // Input conditioning
  logic hs_lvl;
  logic hs_rise;
  logic co_lvl;
  logic ck_rise;

  pcpc_sync_cond u_hsync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_hsync),
    .i_invert  (ctrl_r[`PCPC_CTRL_SYNC_INV]),
    .o_level   (hs_lvl),
    .o_rise    (hs_rise)
  );

  pcpc_sync_cond u_coast (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_coast),
    .i_invert  (ctrl_r[`PCPC_CTRL_COAST_INV]),
    .o_level   (co_lvl),
    .o_rise    ()
  );

  pcpc_sync_cond u_extclk (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_ext_clk),
    .i_invert  (1'b0),
    .o_level   (),
    .o_rise    (ck_rise)
  );

  always_comb begin
    div_nxt   = div_r;
    band_nxt  = band_r;
    pump_nxt  = pump_r;
    phase_nxt = phase_r;
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `PCPC_ADDR_DIV_HI:    div_nxt = {i_reg_wdata, div_r[3:0]};
        `PCPC_ADDR_DIV_LO:    div_nxt = {div_r[11:4], i_reg_wdata[7:4]};
        `PCPC_ADDR_BAND_PUMP: begin
          band_nxt = pcpc_band_e'(i_reg_wdata[`PCPC_BAND_LSB +: 2]);
          pump_nxt = i_reg_wdata[`PCPC_PUMP_LSB +: 3];
        end
        `PCPC_ADDR_PHASE:     phase_nxt = i_reg_wdata[`PCPC_PHASE_LSB +: 5];
        `PCPC_ADDR_CTRL:      ctrl_nxt = i_reg_wdata[2:0];
        default:              ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `PCPC_ADDR_DIV_HI:    rdata_nxt = div_r[11:4];
        `PCPC_ADDR_DIV_LO:    rdata_nxt = {div_r[3:0], 4'h0};
        `PCPC_ADDR_BAND_PUMP: rdata_nxt = {band_r, pump_r, 3'h0};
        `PCPC_ADDR_PHASE:     rdata_nxt = {phase_r, 3'h0};
        `PCPC_ADDR_CTRL:      rdata_nxt = {5'h00, ctrl_r};
        `PCPC_ADDR_STATUS:    rdata_nxt = {6'h00, co_lvl, locked_r};
        default:              rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r   <= `PCPC_RST_DIV;
      band_r  <= pcpc_band_e'(`PCPC_RST_BAND);
      pump_r  <= `PCPC_RST_PUMP;
      phase_r <= `PCPC_RST_PHASE;
      ctrl_r  <= `PCPC_RST_CTRL;
      rdata_r <= 8'h00;
    end else begin
      div_r   <= div_nxt;
      band_r  <= band_nxt;
      pump_r  <= pump_nxt;
      phase_r <= phase_nxt;
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Loop group: accumulator oscillator, feedback divider, bang-bang steering
  pcpc_freq_t  acc_r;
  pcpc_freq_t  acc_nxt;
  pcpc_freq_t  freq_r;
  pcpc_freq_t  freq_nxt;
  logic [12:0] fb_cnt_r;
  logic [12:0] fb_cnt_nxt;
  logic [3:0]  lock_cnt_r;
  logic [3:0]  lock_cnt_nxt;
  logic        osc_tick;
  logic        raw_tick;
  logic [32:0] acc_sum;
  logic [12:0] ratio;
  logic [32:0] step;
  logic [32:0] f_up;
  logic [32:0] f_dn;

  always_comb begin
    acc_sum  = {1'b0, acc_r} + {1'b0, freq_r};
    acc_nxt  = acc_sum[31:0];
    osc_tick = acc_sum[32];
    raw_tick = ctrl_r[`PCPC_CTRL_EXT_SEL] ? ck_rise : osc_tick;
    ratio    = {1'b0, div_r} + 13'h0001;
    step     = 33'h0_0000_0001 << (`PCPC_STEP_SHIFT + 32'(pump_r));
    f_up     = {1'b0, freq_r} + step;
    f_dn     = {1'b0, freq_r} - step;
    freq_nxt     = freq_r;
    lock_cnt_nxt = lock_cnt_r;
    fb_cnt_nxt   = (raw_tick && fb_cnt_r != 13'h1FFF) ? fb_cnt_r + 13'h0001 : fb_cnt_r;
    // Coast masks the reference edge, so only the band clamp below can move the word
    if (hs_rise && !co_lvl) begin
      fb_cnt_nxt = 13'h0000;
      if (fb_cnt_r < ratio) begin
        freq_nxt     = f_up[32] ? 32'hFFFF_FFFF : f_up[31:0];
        lock_cnt_nxt = 4'h0;
      end else if (fb_cnt_r > ratio) begin
        freq_nxt     = f_dn[32] ? 32'h0000_0000 : f_dn[31:0];
        lock_cnt_nxt = 4'h0;
      end else if (lock_cnt_r != `PCPC_LOCK_LINES) begin
        lock_cnt_nxt = lock_cnt_r + 4'h1;
      end
    end
    // Band limits the oscillator region, also on a later band change
    if (freq_nxt < band_min(band_r)) begin
      freq_nxt = band_min(band_r);
    end else if (freq_nxt > band_max(band_r)) begin
      freq_nxt = band_max(band_r);
    end
    locked_nxt = (lock_cnt_nxt == `PCPC_LOCK_LINES);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_r      <= 32'h0000_0000;
      freq_r     <= 32'h0000_0000;
      fb_cnt_r   <= 13'h0000;
      lock_cnt_r <= 4'h0;
      locked_r   <= 1'b0;
    end else begin
      acc_r      <= acc_nxt;
      freq_r     <= freq_nxt;
      fb_cnt_r   <= fb_cnt_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      locked_r   <= locked_nxt;
    end
  end

  // Phase group: delay each pixel tick by phase/32 of the measured period
  logic [7:0]  per_cnt_r;
  logic [7:0]  per_cnt_nxt;
  logic [7:0]  per_r;
  logic [7:0]  per_nxt;
  logic [7:0]  dly_r;
  logic [7:0]  dly_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        hs_hold_r;
  logic        hs_hold_nxt;
  logic        smp_r;
  logic        smp_nxt;
  logic        hs_out_r;
  logic        hs_out_nxt;
  logic [12:0] dly_prod;

  always_comb begin
    per_cnt_nxt = (per_cnt_r != 8'hFF) ? per_cnt_r + 8'h01 : per_cnt_r;
    per_nxt     = per_r;
    dly_nxt     = dly_r;
    pend_nxt    = pend_r;
    hs_hold_nxt = hs_hold_r;
    smp_nxt     = 1'b0;
    hs_out_nxt  = hs_out_r;
    dly_prod    = 13'(per_r) * 13'(phase_r);
    if (pend_r) begin
      if (dly_r == 8'h00) begin
        smp_nxt    = 1'b1;
        hs_out_nxt = hs_hold_r;
        pend_nxt   = 1'b0;
      end else begin
        dly_nxt = dly_r - 8'h01;
      end
    end
    // Same path for both sources keeps the shift with an external clock
    if (raw_tick) begin
      per_nxt     = per_cnt_r;
      per_cnt_nxt = 8'h01;
      dly_nxt     = dly_prod[12:5];
      pend_nxt    = 1'b1;
      hs_hold_nxt = hs_lvl;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      per_cnt_r <= 8'h00;
      per_r     <= 8'h00;
      dly_r     <= 8'h00;
      pend_r    <= 1'b0;
      hs_hold_r <= 1'b0;
      smp_r     <= 1'b0;
      hs_out_r  <= 1'b0;
    end else begin
      per_cnt_r <= per_cnt_nxt;
      per_r     <= per_nxt;
      dly_r     <= dly_nxt;
      pend_r    <= pend_nxt;
      hs_hold_r <= hs_hold_nxt;
      smp_r     <= smp_nxt;
      hs_out_r  <= hs_out_nxt;
    end
  end

  assign o_reg_rdata           = rdata_r;
  assign o_sample_clk_en       = smp_r;
  assign o_aligned_sync_output = hs_out_r;
  assign o_band_select_high    = band_r[1];
  assign o_band_select_low     = band_r[0];
  assign o_pump_code           = pump_r;
  assign o_freq_word           = freq_r;
  assign o_locked              = locked_r;
endmodule
`default_nettype wire

/* File: test/pcpc_pll_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pcpc_pll_ctrl_monitor (
  input wire logic                 i_sys_clk,
  input wire logic                 i_rstn,
  input wire logic                 i_reg_wr,
  input wire logic                 i_reg_rd,
  input wire pcpc_pkg::pcpc_byte_t i_reg_addr,
  input wire pcpc_pkg::pcpc_byte_t i_reg_wdata,
  input wire pcpc_pkg::pcpc_byte_t o_reg_rdata,
  input wire logic                 i_coast,
  input wire logic                 o_sample_clk_en,
  input wire logic                 o_aligned_sync_output,
  input wire logic                 o_band_select_high,
  input wire logic                 o_band_select_low,
  input wire logic [2:0]           o_pump_code,
  input wire pcpc_pkg::pcpc_freq_t o_freq_word
);
  import pcpc_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic       inv_r, inv_nxt;
  logic [3:0] co_r, co_nxt;
  pcpc_byte_t wd_r, wd_nxt;
  wire        w03 = i_reg_wr && i_reg_addr == 8'h03;
  wire        rok = i_reg_rd && !i_reg_wr;
  // Coast age restarts on any write so a band clamp is never mistaken for drift
  always_comb begin
    inv_nxt = inv_r;
    wd_nxt  = i_reg_wdata;
    co_nxt  = (co_r == 4'hF) ? co_r : co_r + 4'h1;
    if (i_reg_wr && i_reg_addr == 8'h05) begin
      inv_nxt = i_reg_wdata[1];
    end
    if (!(i_coast ^ inv_r) || i_reg_wr) begin
      co_nxt = 4'h0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      inv_r <= 1'b0;
      co_r  <= 4'h0;
      wd_r  <= 8'h00;
    end else begin
      inv_r <= inv_nxt;
      co_r  <= co_nxt;
      wd_r  <= wd_nxt;
    end
  end
  property p_rst;
    $rose(i_rstn) |-> {o_band_select_high, o_band_select_low} == 2'h1 && o_pump_code == 3'h5;
  endproperty
  a_rst: assert property (p_rst) else $error("reset band or pump wrong");
  property p_band_wr;
    w03 |=> {o_band_select_high, o_band_select_low} == wd_r[7:6];
  endproperty
  a_band_wr: assert property (p_band_wr) else $error("band not loaded");
  property p_pump_wr;
    w03 |=> o_pump_code == wd_r[5:3];
  endproperty
  a_pump_wr: assert property (p_pump_wr) else $error("pump not loaded");
  property p_rd_band;
    rok && i_reg_addr == 8'h03 |=>
      o_reg_rdata[7:3] == {o_band_select_high, o_band_select_low, o_pump_code};
  endproperty
  a_rd_band: assert property (p_rd_band) else $error("band readback wrong");
  property p_rd_unm;
    rok && (i_reg_addr == 8'h00 || i_reg_addr > 8'h06) |=> o_reg_rdata == 8'h00;
  endproperty
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  property p_rd_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_coast;
    co_r >= 4'h8 |-> $stable(o_freq_word);
  endproperty
  a_coast: assert property (p_coast) else $error("frequency moved in coast");
  property p_align;
    $changed(o_aligned_sync_output) |-> o_sample_clk_en || $past(o_sample_clk_en);
  endproperty
  a_align: assert property (p_align) else $error("sync out off sample edge");
endmodule
`default_nettype wire

/* File: test/pcpc_sync_source.sv */
`timescale 1ns/1ps
`default_nettype none
module pcpc_sync_source (
  input  wire logic        i_sys_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_period,
  output logic             o_hsync
);
  logic [15:0] cnt_r;
  // Idle low while stopped, so a stalled source never looks like a held pulse
  always @(posedge i_sys_clk) begin
    cnt_r   <= (!i_run || cnt_r >= i_period - 16'h1) ? 16'h0 : cnt_r + 16'h1;
    o_hsync <= i_run && cnt_r < 16'h10;
  end
endmodule
`default_nettype wire

/* File: test/tb_pixel_clock_pll_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_pixel_clock_pll_control;
  import pcpc_pkg::*;
  logic       i_sys_clk, i_rstn, i_reg_wr, i_reg_rd, i_coast, i_ext_clk, run, hs, ext_en;
  logic       o_sample_clk_en, o_aligned_sync_output, o_band_select_high;
  logic       o_band_select_low, o_locked;
  logic [2:0] o_pump_code;
  logic [3:0] ext_cnt = 4'h0, e0, dd;
  pcpc_byte_t i_reg_addr, i_reg_wdata, o_reg_rdata, rd_v;
  pcpc_freq_t o_freq_word, f1;
  int         miscompares = 0, checks_done = 0, i, ph;
  pcpc_byte_t rv [4]  = '{8'h53, 8'hF0, 8'h68, 8'h00};
  pcpc_byte_t ra [12] = '{8'h01, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03,
                          8'h04, 8'h04, 8'h05, 8'h05, 8'h07, 8'h00};
  pcpc_byte_t rw [12] = '{8'hA5, 8'h30, 8'h00, 8'h58, 8'hB0, 8'hF8,
                          8'hF8, 8'h40, 8'h07, 8'h00, 8'hFF, 8'h12};
  pcpc_byte_t re [12] = '{8'hA5, 8'h30, 8'h00, 8'h58, 8'hB0, 8'hF8,
                          8'hF8, 8'h40, 8'h07, 8'h00, 8'h00, 8'h00};
  pcpc_pll_ctrl pcpc_pll_ctrl_inst (.i_sys_clk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_hsync(hs), .i_coast, .i_ext_clk, .o_sample_clk_en,
    .o_aligned_sync_output, .o_band_select_high, .o_band_select_low, .o_pump_code,
    .o_freq_word, .o_locked);
  pcpc_sync_source pcpc_sync_source_inst (.i_sys_clk, .i_run(run), .i_period(16'h03E8),
    .o_hsync(hs));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    ext_cnt   <= ext_cnt + 4'h1;
    i_ext_clk <= ext_en & ext_cnt[3];
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input pcpc_byte_t a, input pcpc_byte_t d);
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  // Settling wait first, since pin status passes a synchroniser
  task automatic rd(input pcpc_byte_t a);
    repeat (4) @(posedge i_sys_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_sys_clk);
    #1 rd_v = o_reg_rdata;
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    results();
  end
  initial begin
    {i_rstn, i_reg_wr, i_reg_rd, i_coast, ext_en, run} = 6'h00;
    {i_reg_addr, i_reg_wdata} = 16'h0000;
    repeat (4) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(8'(i + 1));
      chk("reset_value", rd_v, rv[i]);
    end
    for (i = 0; i < 12; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i]);
      chk("rdata", rd_v, re[i]);
      if (ra[i] == 8'h03) begin
        chk("band", {o_band_select_high, o_band_select_low}, rw[i][7:6]);
        chk("pump", o_pump_code, rw[i][5:3]);
      end
    end
    @(posedge i_sys_clk);
    {i_reg_wr, i_reg_rd} <= 2'h3;
    i_reg_addr  <= 8'h04;
    i_reg_wdata <= 8'h88;
    @(posedge i_sys_clk);
    {i_reg_wr, i_reg_rd} <= 2'h0;
    @(posedge i_sys_clk);
    #1 chk("rd_old", o_reg_rdata, 8'h40);
    rd(8'h04);
    chk("rd_new", rd_v, 8'h88);
    // Word starts at the 70 MHz band top, above the 65 MHz target, so every line steps down
    wr(8'h01, 8'h28);
    wr(8'h02, 8'h90);
    wr(8'h03, 8'h70);
    run <= 1'b1;
    repeat (2500) @(posedge i_sys_clk);
    #1 f1 = o_freq_word;
    repeat (1000) @(posedge i_sys_clk);
    #1 chk("freq_step", o_freq_word, f1 - 32'h4000);
    chk("unlocked", o_locked, 1'b0);
    @(posedge i_sys_clk);
    i_coast <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    #1 f1 = o_freq_word;
    repeat (3000) @(posedge i_sys_clk);
    #1 chk("coast_hold", o_freq_word, f1);
    rd(8'h06);
    chk("coast_stat", rd_v[1], 1'b1);
    @(posedge i_sys_clk);
    i_coast <= 1'b0;
    wr(8'h05, 8'h02);
    rd(8'h06);
    chk("coast_inv", rd_v[1], 1'b1);
    wr(8'h05, 8'h04);
    ext_en <= 1'b1;
    for (ph = 0; ph < 32; ph += 8) begin
      wr(8'h04, {ph[4:0], 3'h0});
      repeat (64) @(posedge i_sys_clk);
      #1;
      for (i = 0; i < 40 && o_sample_clk_en !== 1'b1; i++) begin
        @(posedge i_sys_clk);
        #1;
      end
      if (ph == 0) begin
        e0 = ext_cnt;
      end
      dd = ext_cnt - e0;
      chk("phase_delay", dd, ph / 2);
    end
    run <= 1'b0;
    repeat (64) @(posedge i_sys_clk);
    #1 chk("sync_out", o_aligned_sync_output, 1'b0);
    wr(8'h05, 8'h05);
    repeat (64) @(posedge i_sys_clk);
    #1 chk("sync_inv", o_aligned_sync_output, 1'b1);
    results();
  end
endmodule
bind pcpc_pll_ctrl pcpc_pll_ctrl_monitor pcpc_pll_ctrl_monitor_inst (.i_sys_clk, .i_rstn,
  .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_coast, .o_sample_clk_en,
  .o_aligned_sync_output, .o_band_select_high, .o_band_select_low, .o_pump_code,
  .o_freq_word);
`default_nettype wire
